/* hw/tsu_top.sv */
`timescale 1ns/1ps
module tsu_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [tsu_pkg::NSAMP*tsu_pkg::SW-1:0] ch0_data,
  input wire logic [tsu_pkg::NSAMP*tsu_pkg::SW-1:0] ch1_data,
  input wire logic fp_front_panel_trigger_connector_i,
  output logic fp_front_panel_trigger_connector_o,
  output logic fp_front_panel_trigger_connector_oe,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe,
  input wire logic [tsu_pkg::NPXI-1:0] pxi_i,
  output logic [tsu_pkg::NPXI-1:0] pxi_o,
  output logic [tsu_pkg::NPXI-1:0] pxi_oe,
  input wire logic [tsu_pkg::NMLV-1:0] mlv_i,
  output logic [tsu_pkg::NMLV-1:0] mlv_o,
  output logic [tsu_pkg::NMLV-1:0] mlv_oe,
  output logic front_panel_trigger_connector_event,
  output logic front_panel_trigger_connector_accept,
  output logic [1:0] front_panel_trigger_connector_pos,
  output logic record_busy
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic past_thr(input logic signed [15:0] s,
                                    input logic signed [15:0] thr, input logic below);
    past_thr = below ? (s < thr) : (s > thr);
  endfunction : past_thr

  function automatic logic edge_hit(input logic cur, input logic prev, input logic fall);
    edge_hit = fall ? (!cur && prev) : (cur && !prev);
  endfunction : edge_hit

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] level_reg, rearm_reg, frame_n_reg, reclen_reg;
  logic [31:0] period_reg;
  logic [tsu_pkg::NBP-1:0] bpdir_reg, bpmask_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;

  wire armed = ctrl_reg[tsu_pkg::C_ARM];
  wire lfall = ctrl_reg[tsu_pkg::C_LFALL];
  wire [2:0] src_sel = ctrl_reg[tsu_pkg::C_SRC +: 3];
  wire [1:0] osrc_sel = ctrl_reg[tsu_pkg::C_OSRC +: 2];
  wire [1:0] port_sel = ctrl_reg[tsu_pkg::C_OPORT +: 2];
  wire out_en = ctrl_reg[tsu_pkg::C_OEN];

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  wire addr_ph = hsel && hready && htrans[1];
  wire [7:0] a8 = haddr[7:0];
  logic [31:0] rd_mux;
  logic lvl_armed_reg, fp_prev_reg, sy_prev_reg, bp_prev_reg;
  logic [15:0] rec_cnt_reg, frame_cnt_reg;
  logic [31:0] int_acc_reg;
  logic [1:0] pos_reg;

  always_comb begin
    if (a8 == tsu_pkg::A_CTRL) rd_mux = ctrl_reg;
    else if (a8 == tsu_pkg::A_LEVEL) rd_mux = {16'h0000, level_reg};
    else if (a8 == tsu_pkg::A_REARM) rd_mux = {16'h0000, rearm_reg};
    else if (a8 == tsu_pkg::A_PERIOD) rd_mux = period_reg;
    else if (a8 == tsu_pkg::A_FRAME) rd_mux = {16'h0000, frame_n_reg};
    else if (a8 == tsu_pkg::A_BPDIR) rd_mux = {25'h0000000, bpdir_reg};
    else if (a8 == tsu_pkg::A_BPMASK) rd_mux = {25'h0000000, bpmask_reg};
    else if (a8 == tsu_pkg::A_RECLEN) rd_mux = {16'h0000, reclen_reg};
    else if (a8 == tsu_pkg::A_STATUS)
      rd_mux = {frame_cnt_reg, 11'h000, pos_reg, rec_cnt_reg != 16'h0000, lvl_armed_reg, armed};
    else rd_mux = 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ph && hwrite;
      if (addr_ph) wr_addr_reg <= a8;
      if (addr_ph && !hwrite) hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= tsu_pkg::R_CTRL;
      level_reg <= tsu_pkg::R_LEVEL;
      rearm_reg <= tsu_pkg::R_REARM;
      period_reg <= tsu_pkg::R_PERIOD;
      frame_n_reg <= tsu_pkg::R_FRAME;
      reclen_reg <= tsu_pkg::R_RECLEN;
      bpdir_reg <= 7'h00;
      bpmask_reg <= 7'h00;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == tsu_pkg::A_CTRL) ctrl_reg <= hwdata;
      else if (wr_addr_reg == tsu_pkg::A_LEVEL) level_reg <= hwdata[15:0];
      else if (wr_addr_reg == tsu_pkg::A_REARM) rearm_reg <= hwdata[15:0];
      else if (wr_addr_reg == tsu_pkg::A_PERIOD) period_reg <= hwdata;
      else if (wr_addr_reg == tsu_pkg::A_FRAME) frame_n_reg <= hwdata[15:0];
      else if (wr_addr_reg == tsu_pkg::A_BPDIR) bpdir_reg <= hwdata[6:0];
      else if (wr_addr_reg == tsu_pkg::A_BPMASK) bpmask_reg <= hwdata[6:0];
      else if (wr_addr_reg == tsu_pkg::A_RECLEN) reclen_reg <= hwdata[15:0];
    end
  end

  // ----------------------------------------
  // Level detector
  // ----------------------------------------
  logic [15:0] smp [tsu_pkg::NSAMP];
  genvar g;
  generate
    for (g = 0; g < tsu_pkg::NSAMP; g++) begin : g_smp
      assign smp[g] = ctrl_reg[tsu_pkg::C_LCHAN] ? ch1_data[g*tsu_pkg::SW +: tsu_pkg::SW]
                                                  : ch0_data[g*tsu_pkg::SW +: tsu_pkg::SW];
    end
  endgenerate

  logic lvl_fire, lvl_arm_next, rearm_seen;
  logic [1:0] lvl_pos;
  always_comb begin
    lvl_arm_next = lvl_armed_reg;
    lvl_fire = 1'b0;
    lvl_pos = 2'b00;
    rearm_seen = 1'b0;
    for (int i = 0; i < tsu_pkg::NSAMP; i++) begin
      if (!lvl_fire && lvl_arm_next && past_thr(smp[i], level_reg, lfall)) begin
        lvl_fire = 1'b1;
        lvl_pos = 2'(i);
        lvl_arm_next = 1'b0;
      end else if (!lvl_arm_next && past_thr(smp[i], rearm_reg, !lfall)) begin
        lvl_arm_next = 1'b1;
        if (!lvl_fire) rearm_seen = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Other sources
  // ----------------------------------------
  // sample-count period
  wire [31:0] acc_sum = int_acc_reg + 32'(tsu_pkg::NSAMP);
  wire [31:0] acc_rem = acc_sum - period_reg;
  wire int_fire = armed && (period_reg != 32'h0000_0000) && (acc_sum >= period_reg);
  wire fp_hit = edge_hit(fp_front_panel_trigger_connector_i, fp_prev_reg, ctrl_reg[tsu_pkg::C_FPFALL]);
  wire sy_hit = edge_hit(sync_i, sy_prev_reg, ctrl_reg[tsu_pkg::C_SYFALL]);
  wire bp_in = |({mlv_i, pxi_i} & bpmask_reg & ~bpdir_reg);
  wire bp_hit = bp_in && !bp_prev_reg;

  logic src_pulse;
  always_comb begin
    case (src_sel)
      tsu_pkg::TSU_SRC_LEVEL: src_pulse = lvl_fire;
      tsu_pkg::TSU_SRC_INT: src_pulse = int_fire;
      tsu_pkg::TSU_SRC_FRONT: src_pulse = fp_hit;
      tsu_pkg::TSU_SRC_SYNC: src_pulse = sy_hit;
      tsu_pkg::TSU_SRC_BP: src_pulse = bp_hit;
      default: src_pulse = 1'b0;
    endcase
  end

  wire event_w = armed && src_pulse;
  wire busy = rec_cnt_reg != 16'h0000;
  wire accept_w = event_w && !busy;
  wire [15:0] frame_inc = frame_cnt_reg + 16'h0001;
  wire frame_hit = event_w && (frame_inc >= frame_n_reg);

  logic out_pulse;
  always_comb begin
    case (osrc_sel)
      tsu_pkg::TSU_OSRC_EVENT: out_pulse = event_w;
      tsu_pkg::TSU_OSRC_ACCEPT: out_pulse = accept_w;
      tsu_pkg::TSU_OSRC_INT: out_pulse = int_fire;
      tsu_pkg::TSU_OSRC_LEVEL: out_pulse = lvl_fire;
      default: out_pulse = 1'b0;
    endcase
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  // single data clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_armed_reg <= 1'b0;
      fp_prev_reg <= 1'b0;
      sy_prev_reg <= 1'b0;
      bp_prev_reg <= 1'b0;
      int_acc_reg <= 32'h0000_0000;
      pos_reg <= 2'b00;
    end else begin
      lvl_armed_reg <= armed ? lvl_arm_next : 1'b0;
      fp_prev_reg <= fp_front_panel_trigger_connector_i;
      sy_prev_reg <= sync_i;
      bp_prev_reg <= bp_in;
      if (!armed) int_acc_reg <= 32'h0000_0000;
      // Drop the excess when the period shrinks
      else if (int_fire) int_acc_reg <= (acc_rem >= period_reg) ? 32'h0000_0000 : acc_rem;
      else int_acc_reg <= acc_sum;
      if (accept_w) pos_reg <= (src_sel == tsu_pkg::TSU_SRC_LEVEL) ? lvl_pos : 2'b00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rec_cnt_reg <= 16'h0000;
    else if (accept_w) rec_cnt_reg <= (reclen_reg == 16'h0000) ? 16'h0001 : reclen_reg;
    else if (busy) rec_cnt_reg <= rec_cnt_reg - 16'h0001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) frame_cnt_reg <= 16'h0000;
    else if (!armed) frame_cnt_reg <= 16'h0000;
    else if (frame_hit) frame_cnt_reg <= 16'h0000;
    else if (event_w) frame_cnt_reg <= frame_inc;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire front_sel = out_en && (port_sel == tsu_pkg::TSU_PORT_FRONT);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_front_panel_trigger_connector_o <= 1'b0;
      fp_front_panel_trigger_connector_oe <= 1'b0;
      pxi_o <= 3'h0;
      pxi_oe <= 3'h0;
      mlv_o <= 4'h0;
      mlv_oe <= 4'h0;
      sync_o <= 1'b0;
      sync_oe <= 1'b0;
    end else begin
      fp_front_panel_trigger_connector_o <= front_sel && out_pulse;
      fp_front_panel_trigger_connector_oe <= front_sel;
      pxi_o <= {3{out_en && port_sel == tsu_pkg::TSU_PORT_PXI && out_pulse}};
      pxi_oe <= bpdir_reg[2:0];
      mlv_o <= {4{out_en && port_sel == tsu_pkg::TSU_PORT_MLV && out_pulse}};
      mlv_oe <= bpdir_reg[6:3];
      sync_o <= ctrl_reg[tsu_pkg::C_FEN] && frame_hit;
      sync_oe <= ctrl_reg[tsu_pkg::C_FEN];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      front_panel_trigger_connector_event <= 1'b0;
      front_panel_trigger_connector_accept <= 1'b0;
      front_panel_trigger_connector_pos <= 2'b00;
      record_busy <= 1'b0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      front_panel_trigger_connector_event <= event_w;
      front_panel_trigger_connector_accept <= accept_w;
      front_panel_trigger_connector_pos <= (accept_w && src_sel == tsu_pkg::TSU_SRC_LEVEL) ? lvl_pos : front_panel_trigger_connector_pos;
      record_busy <= accept_w || (rec_cnt_reg > 16'h0001);
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = hrdata_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire [15:0] fire_smp = smp[lvl_pos];
  sequence s_accept; accept_w; endsequence
  sequence s_held; busy [*2]; endsequence

  AST_BUSY_BLOCK: assert property (busy |-> !accept_w)
    else $error("trigger accepted during record");
  AST_ACCEPT_BUSY: assert property (s_accept and (reclen_reg > 16'h0002) |=> s_held)
    else $error("record window not held");
  AST_POS_BEYOND: assert property (lvl_fire |-> past_thr(fire_smp, level_reg, lfall))
    else $error("position sample not beyond threshold");
  AST_REARM: assert property (lvl_fire |-> (lvl_armed_reg || rearm_seen))
    else $error("level fired while disarmed");
  AST_EVT_OUT: assert property (event_w && osrc_sel == tsu_pkg::TSU_OSRC_EVENT && front_sel
    |=> fp_front_panel_trigger_connector_o && front_panel_trigger_connector_event)
    else $error("event not shown on output");
  AST_FRAME_PULSE: assert property (sync_o |-> $past(event_w) && $past(frame_inc) >=
    $past(frame_n_reg))
    else $error("frame pulse without count");
  AST_DISARM_CLR: assert property (!armed |=> frame_cnt_reg == 16'h0000)
    else $error("frame count not cleared");
  AST_FP_EDGE: assert property (armed && src_sel == tsu_pkg::TSU_SRC_FRONT &&
    $rose(fp_front_panel_trigger_connector_i) && !ctrl_reg[tsu_pkg::C_FPFALL] |=> front_panel_trigger_connector_event)
    else $error("front edge missed");
  AST_BP_OR: assert property (armed && src_sel == tsu_pkg::TSU_SRC_BP && bp_in && !bp_prev_reg
    |=> front_panel_trigger_connector_event)
    else $error("backplane input missed");
  AST_PERIOD: assert property (int_fire && period_reg >= 32'(2*tsu_pkg::NSAMP) |=> !int_fire)
    else $error("periodic trigger too early");
endmodule : tsu_top

/* hw/tsu_pkg.sv */
package tsu_pkg;
  // ----------------------------------------
  // Data path shape
  // ----------------------------------------
  localparam int NSAMP = 4;
  localparam int SW = 16;
  localparam int NPXI = 3;
  localparam int NMLV = 4;
  localparam int NBP = 7;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LEVEL = 8'h04;
  localparam logic [7:0] A_REARM = 8'h08;
  localparam logic [7:0] A_PERIOD = 8'h0C;
  localparam logic [7:0] A_FRAME = 8'h10;
  localparam logic [7:0] A_BPDIR = 8'h14;
  localparam logic [7:0] A_BPMASK = 8'h18;
  localparam logic [7:0] A_RECLEN = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int C_ARM = 0;
  localparam int C_LFALL = 1;
  localparam int C_LCHAN = 2;
  localparam int C_SRC = 3;
  localparam int C_FPFALL = 6;
  localparam int C_SYFALL = 7;
  localparam int C_OSRC = 8;
  localparam int C_OPORT = 10;
  localparam int C_OEN = 12;
  localparam int C_FEN = 13;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] R_CTRL = 32'h0000_0000;
  localparam logic [15:0] R_LEVEL = 16'h1000;
  localparam logic [15:0] R_REARM = 16'h0800;
  localparam logic [31:0] R_PERIOD = 32'h0000_0400;
  localparam logic [15:0] R_FRAME = 16'h0010;
  localparam logic [15:0] R_RECLEN = 16'h0040;
  // ----------------------------------------
  // Selections
  // ----------------------------------------
  typedef enum logic [2:0] {
    TSU_SRC_LEVEL, TSU_SRC_INT, TSU_SRC_FRONT, TSU_SRC_SYNC, TSU_SRC_BP
  } tsu_src_t;
  typedef enum logic [1:0] {
    TSU_OSRC_EVENT, TSU_OSRC_ACCEPT, TSU_OSRC_INT, TSU_OSRC_LEVEL
  } tsu_osrc_t;
  typedef enum logic [1:0] {TSU_PORT_FRONT, TSU_PORT_PXI, TSU_PORT_MLV} tsu_port_t;
endpackage : tsu_pkg

/* tb/tsu_peer.sv */
`timescale 1ns/1ps
module tsu_peer (
  input wire logic fp_lvl,
  input wire logic sync_lvl,
  input wire logic [tsu_pkg::NPXI-1:0] pxi_lvl,
  input wire logic [tsu_pkg::NMLV-1:0] mlv_lvl,
  input wire logic fp_front_panel_trigger_connector_o,
  input wire logic fp_front_panel_trigger_connector_oe,
  input wire logic sync_o,
  input wire logic sync_oe,
  input wire logic [tsu_pkg::NPXI-1:0] pxi_o,
  input wire logic [tsu_pkg::NPXI-1:0] pxi_oe,
  input wire logic [tsu_pkg::NMLV-1:0] mlv_o,
  input wire logic [tsu_pkg::NMLV-1:0] mlv_oe,
  output logic fp_w,
  output logic sync_w,
  output logic [tsu_pkg::NPXI-1:0] pxi_w,
  output logic [tsu_pkg::NMLV-1:0] mlv_w
);
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // shared front connector
  assign fp_w = fp_front_panel_trigger_connector_oe ? fp_front_panel_trigger_connector_o : fp_lvl;
  assign sync_w = sync_oe ? sync_o : sync_lvl;
  assign pxi_w = (pxi_oe & pxi_o) | (~pxi_oe & pxi_lvl);
  assign mlv_w = (mlv_oe & mlv_o) | (~mlv_oe & mlv_lvl);
endmodule : tsu_peer

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, front_panel_trigger_connector_pos;
  logic [2:0] hsize, pxi_lvl, pxi_w, pxi_o, pxi_oe;
  logic [3:0] mlv_lvl, mlv_w, mlv_o, mlv_oe;
  logic [63:0] ch0, ch1;
  logic fp_lvl, sync_lvl, fp_w, sync_w, fp_front_panel_trigger_connector_o, fp_front_panel_trigger_connector_oe, sync_o, sync_oe;
  logic front_panel_trigger_connector_event, front_panel_trigger_connector_accept, record_busy;
  int errors, n_compared, n_ev, n_acc, n_sy, n_px, n_fp, b_ev, b_acc, b_sy, b_px, b_fp;
  assign hready = hreadyout;
  tsu_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch0_data(ch0), .ch1_data(ch1), .fp_front_panel_trigger_connector_i(fp_w),
    .fp_front_panel_trigger_connector_o(fp_front_panel_trigger_connector_o), .fp_front_panel_trigger_connector_oe(fp_front_panel_trigger_connector_oe), .sync_i(sync_w), .sync_o(sync_o),
    .sync_oe(sync_oe), .pxi_i(pxi_w), .pxi_o(pxi_o), .pxi_oe(pxi_oe), .mlv_i(mlv_w),
    .mlv_o(mlv_o), .mlv_oe(mlv_oe), .front_panel_trigger_connector_event(front_panel_trigger_connector_event), .front_panel_trigger_connector_accept(front_panel_trigger_connector_accept),
    .front_panel_trigger_connector_pos(front_panel_trigger_connector_pos), .record_busy(record_busy));
  tsu_peer peer_u (.fp_lvl(fp_lvl), .sync_lvl(sync_lvl), .pxi_lvl(pxi_lvl), .mlv_lvl(mlv_lvl),
    .fp_front_panel_trigger_connector_o(fp_front_panel_trigger_connector_o), .fp_front_panel_trigger_connector_oe(fp_front_panel_trigger_connector_oe), .sync_o(sync_o), .sync_oe(sync_oe),
    .pxi_o(pxi_o), .pxi_oe(pxi_oe), .mlv_o(mlv_o), .mlv_oe(mlv_oe), .fp_w(fp_w),
    .sync_w(sync_w), .pxi_w(pxi_w), .mlv_w(mlv_w));
  // ----------------------------------------
  // Clock and pulse monitor
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(negedge hclk) begin
    if (fp_front_panel_trigger_connector_o === 1'b1) n_fp++;
    if (front_panel_trigger_connector_event === 1'b1) n_ev++;
    if (front_panel_trigger_connector_accept === 1'b1) n_acc++;
    if (sync_o === 1'b1) n_sy++;
    if (pxi_o[1] === 1'b1) n_px++;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic conclude();
    $display("Counts: compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(a, 1'b1, v);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle
  task automatic snap();
    b_ev = n_ev;
    b_acc = n_acc;
    b_sy = n_sy;
    b_px = n_px;
    b_fp = n_fp;
  endtask : snap
  task automatic cnt_chk(input int ev, input int acc, input int sy, input int px);
    chk(32'(n_ev - b_ev), 32'(ev));
    chk(32'(n_acc - b_acc), 32'(acc));
    chk(32'(n_sy - b_sy), 32'(sy));
    chk(32'(n_px - b_px), 32'(px));
  endtask : cnt_chk
  task automatic lines(input logic f, input logic [2:0] p, input logic [3:0] m);
    @(posedge hclk);
    fp_lvl <= f;
    pxi_lvl <= p;
    mlv_lvl <= m;
  endtask : lines
  task automatic pulse(input logic f, input logic [2:0] p, input logic [3:0] m);
    lines(f, p, m);
    idle(2);
    lines(1'b0, 3'h0, 4'h0);
    idle(4);
  endtask : pulse
  task automatic samp(input logic [63:0] a, input logic [63:0] b, input int n);
    @(posedge hclk);
    ch0 <= a;
    ch1 <= b;
    idle(n);
  endtask : samp
  function automatic logic [63:0] wd4(input int s0, input int s1, input int s2, input int s3);
    return {16'(s3), 16'(s2), 16'(s1), 16'(s0)};
  endfunction : wd4
  function automatic logic [31:0] cw(input logic [2:0] s, input logic [1:0] os,
      input logic [1:0] p, input logic [31:0] f);
    return 32'h1 | (32'(s) << tsu_pkg::C_SRC) | (32'(os) << tsu_pkg::C_OSRC)
      | (32'(p) << tsu_pkg::C_OPORT) | f;
  endfunction : cw
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #(25 * 8000);
    errors++;
    conclude();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    htrans = 2'h0; hsize = 3'h2; ch0 = 64'h0; ch1 = 64'h0; fp_lvl = 1'b0; sync_lvl = 1'b0;
    pxi_lvl = 3'h0; mlv_lvl = 4'h0; errors = 0; n_compared = 0;
    n_ev = 0; n_acc = 0; n_sy = 0; n_px = 0; n_fp = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(tsu_pkg::A_CTRL, tsu_pkg::R_CTRL);
    rd_chk(tsu_pkg::A_LEVEL, {16'h0000, tsu_pkg::R_LEVEL});
    rd_chk(tsu_pkg::A_REARM, {16'h0000, tsu_pkg::R_REARM});
    rd_chk(tsu_pkg::A_PERIOD, tsu_pkg::R_PERIOD);
    rd_chk(tsu_pkg::A_FRAME, {16'h0000, tsu_pkg::R_FRAME});
    rd_chk(tsu_pkg::A_RECLEN, {16'h0000, tsu_pkg::R_RECLEN});
    rd_chk(tsu_pkg::A_STATUS, 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    rd_chk(8'h24, 32'h0000_0000);
    $display("Test reset values done");
    wr(tsu_pkg::A_RECLEN, 32'h0000_0008);
    wr(tsu_pkg::A_LEVEL, 32'h0000_0064);
    wr(tsu_pkg::A_REARM, 32'h0000_0032);
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_LEVEL, tsu_pkg::TSU_OSRC_EVENT, 2'h1, 32'h0));
    snap();
    samp(wd4(0, 0, 200, 200), 64'h0, 0);
    samp(wd4(200, 200, 200, 200), 64'h0, 3);
    cnt_chk(1, 1, 0, 0);
    chk({30'h0, front_panel_trigger_connector_pos}, 32'h2);
    chk({31'h0, record_busy}, 32'h1);
    snap();
    samp(64'h0, 64'h0, 1);
    samp(wd4(200, 200, 200, 200), 64'h0, 2);
    cnt_chk(1, 0, 0, 0);
    samp(64'h0, 64'h0, 10);
    snap();
    samp(wd4(0, 0, 0, 200), 64'h0, 0);
    samp(wd4(200, 200, 200, 200), 64'h0, 3);
    cnt_chk(1, 1, 0, 0);
    chk({30'h0, front_panel_trigger_connector_pos}, 32'h3);
    samp(64'h0, 64'h0, 10);
    $display("Test level rising done");
    wr(tsu_pkg::A_REARM, 32'h0000_00C8);
    samp(64'h0, wd4(300, 300, 300, 300), 1);
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_LEVEL, tsu_pkg::TSU_OSRC_EVENT, 2'h1, 32'h6));
    idle(3);
    snap();
    samp(64'h0, wd4(300, 50, 50, 50), 0);
    samp(64'h0, wd4(50, 50, 50, 50), 3);
    cnt_chk(1, 1, 0, 0);
    chk({30'h0, front_panel_trigger_connector_pos}, 32'h1);
    samp(64'h0, 64'h0, 10);
    $display("Test level falling done");
    wr(tsu_pkg::A_FRAME, 32'h0000_0002);
    wr(tsu_pkg::A_RECLEN, 32'h0000_0001);
    wr(tsu_pkg::A_BPDIR, 32'h0000_0002);
    idle(1);
    @(negedge hclk);
    chk({29'h0, pxi_oe}, 32'h2);
    wr(tsu_pkg::A_CTRL, 32'h0000_0000);
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_FRONT, tsu_pkg::TSU_OSRC_EVENT, 2'h1, 32'h3000));
    snap();
    for (int i = 0; i < 4; i++) pulse(1'b1, 3'h0, 4'h0);
    cnt_chk(4, 4, 2, 4);
    pulse(1'b1, 3'h0, 4'h0);
    wr(tsu_pkg::A_CTRL, 32'h0000_0000);
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_FRONT, tsu_pkg::TSU_OSRC_EVENT, 2'h1, 32'h3040));
    snap();
    lines(1'b1, 3'h0, 4'h0);
    idle(4);
    cnt_chk(0, 0, 0, 0);
    lines(1'b0, 3'h0, 4'h0);
    idle(4);
    cnt_chk(1, 1, 0, 1);
    $display("Test front edge and frame sync done");
    wr(tsu_pkg::A_BPDIR, 32'h0000_0000);
    wr(tsu_pkg::A_BPMASK, 32'h0000_0014);
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_BP, tsu_pkg::TSU_OSRC_EVENT, 2'h2, 32'h0));
    snap();
    pulse(1'b0, 3'h0, 4'h1);
    cnt_chk(0, 0, 0, 0);
    pulse(1'b0, 3'h0, 4'h2);
    pulse(1'b0, 3'h4, 4'h0);
    cnt_chk(2, 2, 0, 0);
    wr(tsu_pkg::A_BPDIR, 32'h0000_0010);
    snap();
    pulse(1'b0, 3'h0, 4'h2);
    cnt_chk(0, 0, 0, 0);
    $display("Test backplane done");
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_SYNC, tsu_pkg::TSU_OSRC_ACCEPT, 2'h0, 32'h1080));
    snap();
    @(posedge hclk);
    sync_lvl <= 1'b1;
    idle(4);
    @(posedge hclk);
    sync_lvl <= 1'b0;
    idle(4);
    cnt_chk(1, 1, 0, 0);
    chk(32'(n_fp - b_fp), 32'd1);
    $display("Test sync edge and front output done");
    wr(tsu_pkg::A_PERIOD, 32'h0000_0010);
    wr(tsu_pkg::A_RECLEN, 32'h0000_0001);
    wr(tsu_pkg::A_CTRL, cw(tsu_pkg::TSU_SRC_INT, tsu_pkg::TSU_OSRC_EVENT, 2'h1, 32'h0));
    idle(8);
    snap();
    idle(40);
    chk(32'(n_ev - b_ev), 32'd10);
    $display("Test internal period done");
    conclude();
  end
endmodule : tb_top
